/* rtl/protected_config_register_bank.sv */
// protected watchdog and device-state configuration register bank
`timescale 1ns/1ps
`default_nettype none
module protected_config_register_bank #(
  parameter int unsigned TICK_SLOW_CYCLES = cfg_bank_pkg::TICK_SLOW_CYC  // cycles of the slow tick
) (
  input  wire logic       clk_sys,              // system clock, 200 MHz
  input  wire logic       rst_n,                // async reset, active low
  input  wire logic       ce,                   // clock enable
  input  wire logic       sclk,                 // serial clock pin
  input  wire logic       cs_n,                 // chip select pin, active low
  input  wire logic       mosi,                 // serial data in pin
  output logic            miso,                 // serial data out
  output logic            miso_oe,              // miso output enable
  input  wire logic       wd_trigger_pin,       // external watchdog trigger pin
  input  wire logic       cfg_unlocked,         // protection key open
  input  wire logic [7:0] settings_cfg,         // pending watchdog settings
  input  wire logic [6:0] closed_cfg,           // pending closed-span code
  input  wire logic       cfg_apply,            // take pending config as active
  output logic [3:0]      wd_error_threshold,   // active error threshold
  output logic            wd_enable_status,     // watchdog running
  output logic            wd_trigger_source,    // 1 serial, 0 pin
  output logic            wd_tick_period,       // 1 slow tick, 0 fast tick
  output logic [12:0]     open_span_len,        // open span in ticks
  output logic [12:0]     closed_span_len,      // closed span in ticks
  output logic            wd_tick,              // one tick pulse
  output logic            wd_service,           // watchdog service pulse
  output logic            monitor_two_request,  // monitor two enable
  output logic            monitor_one_request,  // monitor one enable
  output logic            step_up_request,      // step-up enable
  output logic            post_reg_request,     // post regulator enable
  output logic [2:0]      state_request_field,  // state request code
  output logic            req_active,           // active requested
  output logic            req_disabled,         // disabled requested
  output logic            req_locked            // locked requested
);
  import cfg_bank_pkg::*;
  localparam logic [14:0] FAST_LIM = 15'(TICK_FAST_CYC - 1);
  localparam logic [14:0] SLOW_LIM = 15'(TICK_SLOW_CYCLES - 1);

  logic [6:0]  addr;
  logic [7:0]  wr_data;
  logic        wr_pulse;
  logic [7:0]  rd_data;
  logic        commit;
  logic [7:0]  commit_data;
  logic [6:0]  open_cfg;
  logic [7:0]  act_settings;
  logic [6:0]  act_closed;
  logic [6:0]  act_open;
  logic [7:0]  state_ctl;
  logic        serial_service_seen;
  logic [14:0] tick_cnt;
  logic [14:0] tick_lim;
  logic [6:0]  next_open_code;
  logic        serial_hit;
  logic        trg_s1;
  logic        trg_s2;
  logic        trg_s3;
  logic        trg_filt;
  logic        trg_filt_d;
  logic        pin_rise;
  logic [15:0] gap;
  logic        gap_ok;

  spi_frame_slave u_spi (
    .clk_sys  (clk_sys),
    .rst_n    (rst_n),
    .ce       (ce),
    .sclk     (sclk),
    .cs_n     (cs_n),
    .mosi     (mosi),
    .rd_data  (rd_data),
    .miso     (miso),
    .miso_oe  (miso_oe),
    .addr     (addr),
    .wr_data  (wr_data),
    .wr_pulse (wr_pulse)
  );

  inverse_pair_guard #(
    .PRIMARY_ADDR (ADDR_STATE_CTL),
    .INVERSE_ADDR (ADDR_STATE_CTL_INV)
  ) u_guard (
    .clk_sys     (clk_sys),
    .rst_n       (rst_n),
    .ce          (ce),
    .wr_pulse    (wr_pulse),
    .wr_addr     (addr),
    .wr_data     (wr_data),
    .commit      (commit),
    .commit_data (commit_data)
  );

  // writable open span: protected, only taken while the key is open; bit 7 dropped
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      open_cfg <= RST_OPEN;
    end else if (ce && wr_pulse && addr == ADDR_OPEN_CFG && cfg_unlocked) begin
      open_cfg <= wr_data[6:0];
    end
  end

  // active copies; mirrors change only on apply, never by a write
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      act_settings <= RST_SETTINGS;
      act_closed   <= RST_CLOSED;
      act_open     <= RST_OPEN;
    end else if (ce && cfg_apply) begin
      act_settings <= settings_cfg & SETTINGS_USED;
      act_closed   <= closed_cfg;
      act_open     <= open_cfg;
    end
  end

  assign wd_error_threshold = act_settings[THR_HI:THR_LO];
  assign wd_enable_status   = act_settings[EN_BIT];
  assign wd_trigger_source  = act_settings[TSEL_BIT];
  assign wd_tick_period     = act_settings[CYC_BIT];

  // span lengths in ticks; open code zero is floored to one step
  assign next_open_code = (act_open == 7'h00) ? 7'h01 : act_open;
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      open_span_len   <= 13'h0000;
      closed_span_len <= 13'h0000;
    end else if (ce) begin
      open_span_len   <= 13'({6'h00, next_open_code} * SPAN_STEP);
      closed_span_len <= 13'({6'h00, act_closed} * SPAN_STEP);
    end
  end

  // tick generator; period follows the active tick selection
  assign tick_lim = wd_tick_period ? SLOW_LIM : FAST_LIM;
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      tick_cnt <= 15'h0000;
      wd_tick  <= 1'b0;
    end else if (ce) begin
      if (!wd_enable_status) begin
        tick_cnt <= 15'h0000;
        wd_tick  <= 1'b0;
      end else if (tick_cnt >= tick_lim) begin
        tick_cnt <= 15'h0000;
        wd_tick  <= 1'b1;
      end else begin
        tick_cnt <= tick_cnt + 15'h0001;
        wd_tick  <= 1'b0;
      end
    end
  end

  // trigger pin crosses in three stages; the first stage feeds only the second
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      trg_s1     <= 1'b0;
      trg_s2     <= 1'b0;
      trg_s3     <= 1'b0;
      trg_filt   <= 1'b0;
      trg_filt_d <= 1'b0;
    end else if (ce) begin
      trg_s1     <= wd_trigger_pin;
      trg_s2     <= trg_s1;
      trg_s3     <= trg_s2;
      trg_filt   <= (trg_s2 == trg_s3) ? trg_s3 : trg_filt;
      trg_filt_d <= trg_filt;
    end
  end
  assign pin_rise   = trg_filt & ~trg_filt_d;
  assign serial_hit = wr_pulse && addr == ADDR_SVC_CMD && wr_data[PULSE_BIT] && wd_trigger_source;

  // service: only the selected source counts; a serial hit sets the record, a pin hit clears it
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      wd_service          <= 1'b0;
      serial_service_seen <= 1'b0;
    end else if (ce) begin
      wd_service <= wd_trigger_source ? serial_hit : pin_rise;
      if (serial_hit) begin
        serial_service_seen <= 1'b1;
      end else if (pin_rise && !wd_trigger_source) begin
        serial_service_seen <= 1'b0;
      end
    end
  end

  // state control only changes through the guarded pair; bit 3 stays zero
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      state_ctl <= RST_STATE_CTL;
    end else if (ce && commit) begin
      state_ctl <= commit_data & STATE_CTL_USED;
    end
  end

  assign monitor_two_request = state_ctl[MON2_BIT];
  assign monitor_one_request = state_ctl[MON1_BIT];
  assign step_up_request     = state_ctl[BOOST_BIT];
  assign post_reg_request    = state_ctl[POST_BIT];
  assign state_request_field = state_ctl[STATE_HI:0];

  // decoded state requests; reserved codes raise nothing
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      req_active   <= 1'b0;
      req_disabled <= 1'b0;
      req_locked   <= 1'b0;
    end else if (ce) begin
      req_active   <= (state_ctl[STATE_HI:0] == STATE_ACTIVE);
      req_disabled <= (state_ctl[STATE_HI:0] == STATE_DISABLED);
      req_locked   <= (state_ctl[STATE_HI:0] == STATE_LOCKED);
    end
  end

  // read mux, registered; unused bits and unmapped addresses read zero
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      rd_data <= 8'h00;
    end else if (ce) begin
      case (addr)
        ADDR_SETTINGS_MIRROR: rd_data <= act_settings;
        ADDR_CLOSED_MIRROR:   rd_data <= {1'b0, act_closed};
        ADDR_OPEN_CFG:        rd_data <= {1'b0, open_cfg};
        ADDR_OPEN_MIRROR:     rd_data <= {1'b0, act_open};
        ADDR_SVC_CMD:         rd_data <= {serial_service_seen, 7'h00};
        ADDR_STATE_CTL:       rd_data <= state_ctl;
        default:              rd_data <= 8'h00;
      endcase
    end
  end

  // helper: enable cycles between ticks while the period is steady
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      gap    <= 16'h0000;
      gap_ok <= 1'b0;
    end else if (ce) begin
      gap <= wd_tick ? 16'h0001 : gap + 16'h0001;
      if (cfg_apply || !wd_enable_status) begin
        gap_ok <= 1'b0;
      end else if (wd_tick) begin
        gap_ok <= 1'b1;
      end
    end
  end

  // guards; reset is left out through disable iff, frozen cycles through ce, except a_state_ctl_guard, which also checks them
  a_open_cfg_locked: assert property (@(posedge clk_sys) disable iff (!rst_n)
    ce && wr_pulse && addr == ADDR_OPEN_CFG && !cfg_unlocked |=> $stable(open_cfg))
    else $error("locked open span was written");

  a_open_cfg_write: assert property (@(posedge clk_sys) disable iff (!rst_n)
    ce && wr_pulse && addr == ADDR_OPEN_CFG && cfg_unlocked |=> open_cfg == $past(wr_data[6:0]))
    else $error("unlocked open span write lost");

  a_open_len_floor: assert property (@(posedge clk_sys) disable iff (!rst_n)
    ce |=> open_span_len == (($past(act_open) == 7'h00) ? SPAN_STEP : 13'($past(act_open) * SPAN_STEP)))
    else $error("open span length wrong");

  a_closed_len_step: assert property (@(posedge clk_sys) disable iff (!rst_n)
    ce |=> closed_span_len == 13'($past(act_closed) * SPAN_STEP))
    else $error("closed span length wrong");

  a_mirror_apply: assert property (@(posedge clk_sys) disable iff (!rst_n)
    ce && cfg_apply |=> act_settings == ($past(settings_cfg) & SETTINGS_USED))
    else $error("settings mirror not applied");

  a_tick_off: assert property (@(posedge clk_sys) disable iff (!rst_n)
    ce && !wd_enable_status |=> !wd_tick)
    else $error("tick while watchdog disabled");

  a_tick_spacing: assert property (@(posedge clk_sys) disable iff (!rst_n)
    ce && wd_tick && gap_ok |-> gap == 16'(tick_lim) + 16'h0001)
    else $error("tick spacing does not match period");

  a_serial_service: assert property (@(posedge clk_sys) disable iff (!rst_n)
    ce && serial_hit |=> wd_service && serial_service_seen)
    else $error("serial service not taken");

  a_pin_ignored: assert property (@(posedge clk_sys) disable iff (!rst_n)
    ce && wd_trigger_source && !serial_hit |=> !wd_service)
    else $error("service from unselected source");

  a_pin_service: assert property (@(posedge clk_sys) disable iff (!rst_n)
    ce && pin_rise && !wd_trigger_source |=> wd_service)
    else $error("pin service not taken");

  a_seen_clear: assert property (@(posedge clk_sys) disable iff (!rst_n)
    ce && pin_rise && !wd_trigger_source |=> !serial_service_seen)
    else $error("serial service record not cleared by pin");

  a_state_ctl_guard: assert property (@(posedge clk_sys) disable iff (!rst_n)
    !(ce && commit) |=> $stable(state_ctl))
    else $error("state control changed without procedure");

  a_state_commit: assert property (@(posedge clk_sys) disable iff (!rst_n)
    ce && commit |=> state_ctl == ($past(commit_data) & STATE_CTL_USED))
    else $error("committed state control value wrong");

  a_state_decode: assert property (@(posedge clk_sys) disable iff (!rst_n)
    ce |=> req_locked == ($past(state_ctl[STATE_HI:0]) == STATE_LOCKED))
    else $error("locked request decode wrong");

  a_mirror_ro: assert property (@(posedge clk_sys) disable iff (!rst_n)
    ce && wr_pulse && addr == ADDR_OPEN_MIRROR && !cfg_apply |=> $stable(act_open))
    else $error("read-only mirror was written");
endmodule
`default_nettype wire

/* common/cfg_bank_pkg.sv */
// constants shared by the protected configuration register bank
// Contract
// - writable open-span code in bits 6:0, code n gives n*50 cycles, zero gives 50
// - mirror bits 7:4 show the active error threshold, 0 to 15
// - mirror bit 3 shows whether the watchdog really runs
// - mirror bit 1 shows trigger source: 0 pin, 1 serial service command
// - mirror bit 0 shows tick period: 0 is 10 us, 1 is 100 us
// - closed-span mirror in bits 6:0, code n gives n*50 cycles
// - open-span mirror in bits 6:0, same coding as the writable open span
// - protected settings are written only while the protection key is open; state control changes only through the two-register inverted procedure
// - state control bits 7..4 request monitor two, monitor one, step-up, post regulator
// - state request bits 2:0: 1 active, 3 disabled, 7 locked, others reserved
// - inverse register at 0x35 must receive the bitwise inverse as second write
// - serial service writes bit 0 of command register, bit 7 records serial service
package cfg_bank_pkg;
  // register addresses
  localparam logic [6:0] ADDR_SETTINGS_MIRROR = 7'h07;
  localparam logic [6:0] ADDR_CLOSED_MIRROR   = 7'h09;
  localparam logic [6:0] ADDR_OPEN_CFG        = 7'h0A;
  localparam logic [6:0] ADDR_OPEN_MIRROR     = 7'h0B;
  localparam logic [6:0] ADDR_SVC_CMD         = 7'h33;
  localparam logic [6:0] ADDR_STATE_CTL       = 7'h34;
  localparam logic [6:0] ADDR_STATE_CTL_INV   = 7'h35;
  // reset values
  localparam logic [7:0] RST_SETTINGS  = 8'h9B;
  localparam logic [6:0] RST_CLOSED    = 7'h46;
  localparam logic [6:0] RST_OPEN      = 7'h78;
  localparam logic [7:0] RST_STATE_CTL = 8'h00;
  localparam logic [2:0] SPI_PIN_IDLE  = 3'h2;
  // masks of used bits
  localparam logic [7:0] SETTINGS_USED  = 8'hFB;
  localparam logic [7:0] STATE_CTL_USED = 8'hF7;
  // field positions
  localparam int THR_HI    = 7;
  localparam int THR_LO    = 4;
  localparam int EN_BIT    = 3;
  localparam int TSEL_BIT  = 1;
  localparam int CYC_BIT   = 0;
  localparam int MON2_BIT  = 7;
  localparam int MON1_BIT  = 6;
  localparam int BOOST_BIT = 5;
  localparam int POST_BIT  = 4;
  localparam int STATE_HI  = 2;
  localparam int PULSE_BIT = 0;
  localparam int SEEN_BIT  = 7;
  // serial frame layout: write flag, 7-bit address, 8-bit data
  localparam logic [4:0] ADDR_LAST_BIT = 5'h07;
  localparam logic [4:0] DATA_FIRST    = 5'h08;
  localparam logic [4:0] FRAME_BITS    = 5'h10;
  // timing
  localparam int         CLK_PERIOD_NS = 5;
  localparam int         TICK_FAST_US  = 10;
  localparam int         TICK_SLOW_US  = 100;
  localparam int         TICK_FAST_CYC = TICK_FAST_US * 1000 / CLK_PERIOD_NS;
  localparam int         TICK_SLOW_CYC = TICK_SLOW_US * 1000 / CLK_PERIOD_NS;
  localparam logic [12:0] SPAN_STEP    = 13'h0032;
  // state request codes
  typedef enum logic [2:0] {
    STATE_ACTIVE   = 3'h1,
    STATE_DISABLED = 3'h3,
    STATE_LOCKED   = 3'h7
  } state_req_e;
endpackage

/* rtl/spi_frame_slave.sv */
// serial frame receiver: pin synchronisers, shift in, read data shift out
`timescale 1ns/1ps
`default_nettype none
module spi_frame_slave (
  input  wire logic       clk_sys,  // system clock
  input  wire logic       rst_n,    // async reset, active low
  input  wire logic       ce,       // clock enable
  input  wire logic       sclk,     // serial clock pin
  input  wire logic       cs_n,     // chip select pin, active low
  input  wire logic       mosi,     // serial data in pin
  input  wire logic [7:0] rd_data,  // read data of addr
  output logic            miso,     // serial data out
  output logic            miso_oe,  // miso driven
  output logic [6:0]      addr,     // frame address
  output logic [7:0]      wr_data,  // frame data
  output logic            wr_pulse  // write frame done
);
  import cfg_bank_pkg::*;
  logic [2:0] pin_raw;
  logic [2:0] s1;
  logic [2:0] s2;
  logic [2:0] s3;
  logic [2:0] filt;
  logic [2:0] filt_d;
  logic [15:0] shift_in;
  logic [7:0]  shift_out;
  logic [4:0]  bit_cnt;
  logic        is_write;
  logic        sclk_rise;
  logic        sclk_fall;
  logic        cs_end;

  assign pin_raw = {sclk, cs_n, mosi};

  // three stages per pin; a level counts once stages two and three agree
  genvar g;
  generate
    for (g = 0; g < 3; g++) begin : g_sync
      always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
          s1[g]     <= SPI_PIN_IDLE[g];
          s2[g]     <= SPI_PIN_IDLE[g];
          s3[g]     <= SPI_PIN_IDLE[g];
          filt[g]   <= SPI_PIN_IDLE[g];
          filt_d[g] <= SPI_PIN_IDLE[g];
        end else if (ce) begin
          s1[g]     <= pin_raw[g];
          s2[g]     <= s1[g];
          s3[g]     <= s2[g];
          filt[g]   <= (s2[g] == s3[g]) ? s3[g] : filt[g];
          filt_d[g] <= filt[g];
        end
      end
    end
  endgenerate

  assign sclk_rise = filt[2] & ~filt_d[2];
  assign sclk_fall = ~filt[2] & filt_d[2];
  assign cs_end    = filt[1] & ~filt_d[1];

  // shift in on rising edges; address is known after eight bits
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      shift_in <= 16'h0000;
      bit_cnt  <= 5'h00;
      addr     <= 7'h00;
      is_write <= 1'b0;
    end else if (ce) begin
      if (filt[1]) begin
        bit_cnt <= 5'h00;
      end else if (sclk_rise) begin
        shift_in <= {shift_in[14:0], filt[0]};
        bit_cnt  <= bit_cnt + 5'h01;
        if (bit_cnt == ADDR_LAST_BIT) begin
          addr     <= {shift_in[5:0], filt[0]};
          is_write <= shift_in[6];
        end
      end
    end
  end

  // writes act only at the end of a frame of 16 bits, or 16 plus a multiple of 32 as bit_cnt wraps; other frames are dropped
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      wr_pulse <= 1'b0;
      wr_data  <= 8'h00;
    end else if (ce) begin
      wr_pulse <= cs_end && is_write && (bit_cnt == FRAME_BITS);
      if (cs_end) begin
        wr_data <= shift_in[7:0];
      end
    end
  end

  // read data go out on falling edges of the data half
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      shift_out <= 8'h00;
      miso      <= 1'b0;
      miso_oe   <= 1'b0;
    end else if (ce) begin
      miso_oe <= ~filt[1];
      if (filt[1]) begin
        miso <= 1'b0;
      end else if (sclk_fall && bit_cnt == DATA_FIRST) begin
        miso      <= rd_data[7];
        shift_out <= {rd_data[6:0], 1'b0};
      end else if (sclk_fall && bit_cnt > DATA_FIRST) begin
        miso      <= shift_out[7];
        shift_out <= {shift_out[6:0], 1'b0};
      end
    end
  end
endmodule
`default_nettype wire

/* rtl/inverse_pair_guard.sv */
// two-write protection: a value commits only when its inverse follows at once
`timescale 1ns/1ps
`default_nettype none
module inverse_pair_guard #(
  parameter logic [6:0] PRIMARY_ADDR = 7'h00,  // first half address
  parameter logic [6:0] INVERSE_ADDR = 7'h01   // second half address
) (
  input  wire logic       clk_sys,     // system clock
  input  wire logic       rst_n,       // async reset, active low
  input  wire logic       ce,          // clock enable
  input  wire logic       wr_pulse,    // write strobe
  input  wire logic [6:0] wr_addr,     // write address
  input  wire logic [7:0] wr_data,     // write data
  output logic            commit,      // one-cycle commit
  output logic [7:0]      commit_data  // value to commit
);
  import cfg_bank_pkg::*;
  logic       armed;
  logic [7:0] pending;
  logic       match;

  assign match = wr_pulse && (wr_addr == INVERSE_ADDR) && armed && (wr_data == ~pending);

  // any write other than the first half disarms, so a stray sequence cannot commit
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      armed   <= 1'b0;
      pending <= RST_STATE_CTL;
    end else if (ce && wr_pulse) begin
      armed <= (wr_addr == PRIMARY_ADDR);
      if (wr_addr == PRIMARY_ADDR) begin
        pending <= wr_data;
      end
    end
  end

  // commit only on an exact inverse
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      commit      <= 1'b0;
      commit_data <= RST_STATE_CTL;
    end else if (ce) begin
      commit <= match;
      if (match) begin
        commit_data <= pending;
      end
    end
  end

  a_inverse_commit: assert property (@(posedge clk_sys) disable iff (!rst_n)
    ce && match |=> commit && (commit_data == $past(pending)))
    else $error("inverse write did not commit pending value");
endmodule
`default_nettype wire

/* sim/spi_master_model.sv */
// serial register master standing in for the microcontroller
`timescale 1ns/1ps
`default_nettype none
module spi_master_model (
  input  wire logic clk_sys,  // bench clock, paces the frames
  output logic      sclk,     // serial clock, idle low
  output logic      cs_n,     // chip select, active low
  output logic      mosi,     // serial data out
  input  wire logic miso      // serial data in
);
  initial begin
    sclk = 1'b0;
    cs_n = 1'b1;
    mosi = 1'b0;
  end
  // ten cycles a phase stays clear of the eight-cycle minimum
  task automatic half();
    repeat (10) @(posedge clk_sys);
    #1;
  endtask
  // one 16-bit frame, msb first; read data taken on rising sclk
  task automatic xfer(input logic [15:0] tx, output logic [7:0] rx);
    rx = 8'h00;
    half();
    cs_n = 1'b0;
    for (int i = 15; i >= 0; i--) begin
      mosi = tx[i];
      half();
      sclk = 1'b1;
      if (i < 8) rx = {rx[6:0], miso};
      half();
      sclk = 1'b0;
    end
    mosi = ~mosi; // released line must not keep the last bit
    half();
    cs_n = 1'b1;
    half();
  endtask
endmodule
`default_nettype wire

/* sim/test_protected_config_register_bank.sv */
// self-checking bench for the protected configuration register bank
`timescale 1ns/1ps
`default_nettype none
module test_protected_config_register_bank;
  import cfg_bank_pkg::*;
  logic        clk_sys = 1'b0;
  logic        rst_n = 1'b0;
  logic        ce = 1'b1;
  logic        sclk, cs_n, mosi, miso, miso_oe, wd_tick, wd_service;
  logic        wd_trigger_pin = 1'b0;
  logic        cfg_unlocked = 1'b0;
  logic        cfg_apply = 1'b0;
  logic [7:0]  settings_cfg = 8'h9B;
  logic [6:0]  closed_cfg = 7'h46;
  logic [3:0]  wd_error_threshold;
  logic        wd_enable_status, wd_trigger_source, wd_tick_period;
  logic [12:0] open_span_len, closed_span_len;
  logic        monitor_two_request, monitor_one_request, step_up_request, post_reg_request;
  logic [2:0]  state_request_field;
  logic        req_active, req_disabled, req_locked;
  int          err_count = 0;
  int          tests_run = 0;
  int          svc = 0;
  logic [31:0] seed = 32'h2CB4B7AB;
  // slow tick shortened to 40 cycles to keep the run brief
  protected_config_register_bank #(.TICK_SLOW_CYCLES(40)) uut (.clk_sys, .rst_n, .ce, .sclk, .cs_n, .mosi,
    .miso, .miso_oe, .wd_trigger_pin, .cfg_unlocked, .settings_cfg, .closed_cfg, .cfg_apply,
    .wd_error_threshold, .wd_enable_status, .wd_trigger_source, .wd_tick_period, .open_span_len,
    .closed_span_len, .wd_tick, .wd_service, .monitor_two_request, .monitor_one_request, .step_up_request,
    .post_reg_request, .state_request_field, .req_active, .req_disabled, .req_locked);
  spi_master_model host (.clk_sys, .sclk, .cs_n, .mosi, .miso);
  always #2.5 clk_sys = ~clk_sys;
  // count service pulses so a missing or doubled one shows
  always @(posedge clk_sys) if (wd_service) svc <= svc + 1;
  function automatic logic [31:0] rnd();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction
  // span in ticks; the open span treats code zero as one step
  function automatic logic [15:0] span(input logic [6:0] c, input logic op);
    return ((op && c == 7'h00) ? 16'h0001 : {9'h000, c}) * 16'h0032;
  endfunction
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    tests_run++;
    if (got !== exp) begin
      err_count++;
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic wr(input logic [6:0] a, input logic [7:0] d);
    logic [7:0] r;
    host.xfer({1'b1, a, d}, r);
  endtask
  task automatic rd(input logic [6:0] a, input logic [7:0] e);
    logic [7:0] r;
    // output enable must stand inside the frame and drop after it
    fork
      host.xfer({1'b0, a, 8'h00}, r);
      begin
        repeat (100) @(posedge clk_sys);
        #1;
        chk({15'h0000, miso_oe}, 16'h0001);
      end
    join
    chk({8'h00, r}, {8'h00, e});
    chk({15'h0000, miso_oe}, 16'h0000);
  endtask
  task automatic apply(input logic [7:0] s, input logic [6:0] c);
    settings_cfg = s;
    closed_cfg = c;
    cfg_apply = 1'b1;
    @(posedge clk_sys);
    #1;
    cfg_apply = 1'b0;
    repeat (3) @(posedge clk_sys);
    #1;
  endtask
  // cycles between two tick pulses, bounded so a dead tick cannot hang
  task automatic gap(input logic [15:0] exp);
    int n;
    n = 0;
    while (wd_tick !== 1'b1 && n < 5000) begin
      @(posedge clk_sys);
      #1;
      n++;
    end
    n = 0;
    do begin
      @(posedge clk_sys);
      #1;
      n++;
    end while (wd_tick !== 1'b1 && n < 5000);
    chk(16'(n), exp);
  endtask
  task automatic end_sim();
    $display("checks %0d mismatches %0d", tests_run, err_count);
    if (err_count == 0 && tests_run > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask
  initial begin
    #400000;
    err_count++;
    end_sim();
  end
  initial begin
    logic [7:0] v, s, e;
    logic [6:0] c;
    int n;
    e = 8'h00;
    repeat (12) @(posedge clk_sys);
    #1;
    rst_n = 1'b1;
    rd(ADDR_SETTINGS_MIRROR, 8'h9B);
    rd(ADDR_CLOSED_MIRROR, 8'h46);
    rd(ADDR_OPEN_MIRROR, 8'h78);
    rd(7'h20, 8'h00);
    wr(ADDR_OPEN_CFG, 8'h11);
    rd(ADDR_OPEN_CFG, 8'h78);
    wr(ADDR_OPEN_MIRROR, 8'h22);
    rd(ADDR_OPEN_MIRROR, 8'h78);
    $display("test reset and protection done");
    // open and closed codes: corners first, then random; settings codes random throughout
    cfg_unlocked = 1'b1;
    for (int i = 0; i < 5; i++) begin
      v = (i == 0) ? 8'h80 : (i == 1) ? 8'h01 : (i == 2) ? 8'hFF : 8'(rnd());
      c = (i == 0) ? 7'h00 : (i == 2) ? 7'h7F : 7'(rnd());
      s = 8'(rnd());
      wr(ADDR_OPEN_CFG, v);
      rd(ADDR_OPEN_CFG, v & 8'h7F);
      apply(s, c);
      rd(ADDR_SETTINGS_MIRROR, s & SETTINGS_USED);
      rd(ADDR_CLOSED_MIRROR, {1'b0, c});
      rd(ADDR_OPEN_MIRROR, v & 8'h7F);
      chk({3'h0, open_span_len}, span(v[6:0], 1'b1));
      chk({3'h0, closed_span_len}, span(c, 1'b0));
      chk({8'h00, wd_error_threshold, wd_enable_status, 1'b0, wd_trigger_source, wd_tick_period}, s & 8'hFB);
    end
    $display("test span codes done");
    // every state code, the first half of the pair checked on its own, then with its inverse
    for (int k = 0; k < 8; k++) begin
      s = 8'(rnd());
      v = {s[7:3], 3'(k)};
      wr(ADDR_STATE_CTL, v);
      rd(ADDR_STATE_CTL, e);
      wr(ADDR_STATE_CTL_INV, ~v);
      e = v & STATE_CTL_USED;
      rd(ADDR_STATE_CTL, e);
      chk({monitor_two_request, monitor_one_request, step_up_request, post_reg_request, 1'b0, state_request_field}, e);
      chk({13'h0000, req_active, req_disabled, req_locked}, {13'h0000, k == 1, k == 3, k == 7});
    end
    wr(ADDR_STATE_CTL, 8'h13);
    wr(ADDR_OPEN_CFG, 8'h05);
    wr(ADDR_STATE_CTL_INV, 8'hEC);
    rd(ADDR_STATE_CTL, e);
    // clock enable low: a whole frame must pass unseen
    ce = 1'b0;
    wr(ADDR_OPEN_CFG, 8'h33);
    ce = 1'b1;
    rd(ADDR_OPEN_CFG, 8'h05);
    $display("test state control done");
    // serial service, then pin service, each ignored under the other source
    apply(8'h9A, 7'h46);
    n = svc;
    wr(ADDR_SVC_CMD, 8'h01);
    rd(ADDR_SVC_CMD, 8'h80);
    wd_trigger_pin = 1'b1;
    repeat (12) @(posedge clk_sys);
    #1;
    wd_trigger_pin = 1'b0;
    chk(16'(svc - n), 16'h0001);
    gap(16'h07D0);
    apply(8'h99, 7'h46);
    wr(ADDR_SVC_CMD, 8'h01);
    wd_trigger_pin = 1'b1;
    repeat (12) @(posedge clk_sys);
    #1;
    wd_trigger_pin = 1'b0;
    repeat (12) @(posedge clk_sys);
    chk(16'(svc - n), 16'h0002);
    rd(ADDR_SVC_CMD, 8'h00);
    gap(16'h0028);
    $display("test service and tick done");
    end_sim();
  end
endmodule
`default_nettype wire
